// [hdl/mmd_decoder.sv]
`timescale 1ns/1ps
// Notes on behaviour
// - register file spans 4096 bytes
// - f00-fff selects control registers, not ram
// - reserved control reads return undefined value
// - 1 KB ram starts at 000
// - gap reads undefined, writes change nothing
// - sources read, destinations written
// - 64KB program space, 4KB or 8KB flash
// - reads beyond flash return ff
// - writes beyond flash ignored
// - options, vectors, then code from 0038
// - code ends 1fff or 0fff by variant
// - data memory space left unimplemented
// - page select bit 7 enables info area
// - enabled info overlays reads fe00-ffff
// - info area read only
// - fe40-fe53 hold 20-char zero-padded part id
module mmd_decoder #(
  parameter bit FLASH_8K = 1'b1, // variant: 8KB when set, else 4KB
  parameter logic [159:0] PART_ID = {8'h4d, 8'h4d, 8'h44, {17{8'h00}}} // arbitrary value
) (
  input wire logic clk_sys, // system clock
  input wire logic resetn, // async reset, active low
  // ==========================================================
  // register file port from core
  input wire logic rf_rd, // source operand read strobe
  input wire logic rf_wr, // destination write strobe
  input wire logic [11:0] rf_addr, // register address
  input wire logic [7:0] rf_wdata, // write data
  output logic [7:0] rf_rdata, // read data, one cycle after rf_rd
  output logic rf_ctl_rd, // read to control section
  output logic rf_ctl_wr, // write to control section
  output logic [7:0] rf_ctl_addr, // control register offset
  output logic [7:0] rf_ctl_wdata, // control write data
  input wire logic [7:0] ctl_rdata, // data from control registers
  // ==========================================================
  // program memory port from core
  input wire logic pm_rd, // program read strobe
  input wire logic pm_wr, // program write strobe
  input wire logic [15:0] pm_addr, // program address
  input wire logic [7:0] pm_wdata, // program write data
  input wire logic [7:0] page_sel, // page select register value
  output logic [7:0] pm_rdata, // read data, one cycle after pm_rd
  output logic fl_rd, // flash read strobe
  output logic fl_wr, // flash write strobe
  output logic [12:0] fl_addr, // flash address
  output logic [7:0] fl_wdata, // flash write data
  input wire logic [7:0] fl_rdata, // flash data, valid in the same cycle as fl_rd
  // ==========================================================
  // data memory port, unused on this device
  input wire logic dm_rd, // data memory read strobe
  output logic [7:0] dm_rdata // data memory read data
);
  // ==========================================================
  // register file decode
  logic [7:0] ram_q [0:mmd_pkg::RF_RAM_BYTES-1];
  mmd_pkg::mmd_rf_region_t rf_region;
  logic rf_in_ram;
  logic rf_in_ctl;
  logic ram_we;
  logic [7:0] ram_rd_q;
  mmd_pkg::mmd_rf_region_t rd_region_q;
  logic [7:0] rf_rdata_d;
  // region by address; 12-bit address covers all 4096 bytes
  assign rf_in_ram = (rf_addr <= mmd_pkg::RF_RAM_LAST);
  assign rf_in_ctl = (rf_addr >= mmd_pkg::RF_CTL_BASE);
  assign rf_region = rf_in_ram ? mmd_pkg::MMD_REG_RAM :
                     rf_in_ctl ? mmd_pkg::MMD_REG_CTL : mmd_pkg::MMD_REG_GAP;
  // only ram writes store; gap writes vanish
  assign ram_we = rf_wr && rf_in_ram;

  // ram array, no reset: contents undefined at power up
  always_ff @(posedge clk_sys) begin
    if (ram_we) begin
      ram_q[rf_addr[9:0]] <= rf_wdata;
    end
    ram_rd_q <= ram_q[rf_addr[9:0]];
  end

  // control section is forwarded; reserved offsets answer whatever it returns
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      rf_ctl_rd <= 1'b0;
      rf_ctl_wr <= 1'b0;
      rf_ctl_addr <= 8'h00;
      rf_ctl_wdata <= 8'h00;
      rd_region_q <= mmd_pkg::MMD_REG_GAP;
    end else begin
      rf_ctl_rd <= rf_rd && rf_in_ctl;
      rf_ctl_wr <= rf_wr && rf_in_ctl;
      rf_ctl_addr <= rf_addr[7:0];
      rf_ctl_wdata <= rf_wdata;
      rd_region_q <= rf_region;
    end
  end

  // read mux; gap reads give a fixed filler, cheaper than tracking ram
  always_comb begin
    rf_rdata_d = ram_rd_q;
    unique case (rd_region_q)
      mmd_pkg::MMD_REG_RAM: rf_rdata_d = ram_rd_q;
      mmd_pkg::MMD_REG_CTL: rf_rdata_d = ctl_rdata;
      mmd_pkg::MMD_REG_GAP: rf_rdata_d = mmd_pkg::RF_GAP_DATA;
      default: rf_rdata_d = mmd_pkg::RF_GAP_DATA;
    endcase
  end
  // control data is valid in the same cycle as rf_ctl_rd, so answer is combinational
  assign rf_rdata = rf_rdata_d;

  // ==========================================================
  // program memory decode
  logic [15:0] flash_last;
  logic pm_in_flash;
  logic pm_in_info;
  logic info_en;
  logic [7:0] info_byte;
  logic [7:0] info_q;
  logic [1:0] pm_src_q;
  logic [7:0] pm_rdata_d;
  // vectors sit inside flash, so their offsets pass through unchanged
  assign flash_last = FLASH_8K ? mmd_pkg::PM_FLASH_LAST_8K :
                                 mmd_pkg::PM_FLASH_LAST_4K;
  assign pm_in_flash = (pm_addr <= flash_last);
  assign info_en = page_sel[mmd_pkg::PAGE_INFO_BIT];
  assign pm_in_info = info_en && (pm_addr >= mmd_pkg::INFO_BASE);

  mmd_info_rom u_info (
    .addr(pm_addr[8:0]),
    .part_id(PART_ID),
    .data(info_byte)
  );

  // strobes to flash; out-of-range and info writes never reach it
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      fl_rd <= 1'b0;
      fl_wr <= 1'b0;
      fl_addr <= 13'h0000;
      fl_wdata <= 8'h00;
      info_q <= 8'h00;
      pm_src_q <= 2'b00;
    end else begin
      fl_rd <= pm_rd && pm_in_flash && !pm_in_info;
      fl_wr <= pm_wr && pm_in_flash && !pm_in_info;
      fl_addr <= pm_addr[12:0];
      fl_wdata <= pm_wdata;
      info_q <= info_byte;
      pm_src_q <= pm_in_info ? 2'b10 : (pm_in_flash ? 2'b01 : 2'b00);
    end
  end

  // source select: info overlay, flash, or erased pattern
  always_comb begin
    pm_rdata_d = mmd_pkg::PM_BLANK;
    unique case (pm_src_q)
      2'b10: pm_rdata_d = info_q;
      2'b01: pm_rdata_d = fl_rdata;
      2'b00: pm_rdata_d = mmd_pkg::PM_BLANK;
      default: pm_rdata_d = mmd_pkg::PM_BLANK;
    endcase
  end
  assign pm_rdata = pm_rdata_d;

  // ==========================================================
  // data memory: not present, reads return zero
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      dm_rdata <= 8'h00;
    end else begin
      dm_rdata <= dm_rd ? mmd_pkg::DM_DATA : mmd_pkg::DM_DATA;
    end
  end

  // ==========================================================
  // checks on the register file side

  // control reads leave with address one cycle later
  AST_CTL_STROBE: assert property (@(posedge clk_sys) disable iff (!resetn)
    rf_rd && rf_addr >= mmd_pkg::RF_CTL_BASE |=> rf_ctl_rd &&
      rf_ctl_addr == $past(rf_addr[7:0]))
    else $error("control read not forwarded");

  // control writes carry address and data
  AST_CTL_WSTROBE: assert property (@(posedge clk_sys) disable iff (!resetn)
    rf_wr && rf_addr >= mmd_pkg::RF_CTL_BASE |=> rf_ctl_wr &&
      rf_ctl_wdata == $past(rf_wdata) && rf_ctl_addr == $past(rf_addr[7:0]))
    else $error("control write not forwarded");

  // reserved control offsets answer whatever the section returns
  AST_CTL_RDATA: assert property (@(posedge clk_sys) disable iff (!resetn)
    rf_rd && rf_addr >= mmd_pkg::RF_CTL_BASE |=> rf_rdata == ctl_rdata)
    else $error("control read data not passed");

  // gap writes reach neither ram nor control
  AST_GAP_NOWRITE: assert property (@(posedge clk_sys) disable iff (!resetn)
    rf_wr && rf_addr > mmd_pkg::RF_RAM_LAST && rf_addr < mmd_pkg::RF_CTL_BASE
      |-> !ram_we ##1 !rf_ctl_wr)
    else $error("gap write had an effect");

  // gap reads give the filler, not a control access
  AST_GAP_RDATA: assert property (@(posedge clk_sys) disable iff (!resetn)
    rf_rd && rf_addr > mmd_pkg::RF_RAM_LAST && rf_addr < mmd_pkg::RF_CTL_BASE
      |=> rf_rdata == mmd_pkg::RF_GAP_DATA && !rf_ctl_rd)
    else $error("gap read wrong");

  // gap decode matches the documented hole exactly
  AST_RF_SPAN: assert property (@(posedge clk_sys) disable iff (!resetn)
    (rf_region == mmd_pkg::MMD_REG_GAP) ==
      (rf_addr > mmd_pkg::RF_RAM_LAST && rf_addr < mmd_pkg::RF_CTL_BASE))
    else $error("register file span decode wrong");

  // ram is the lowest kilobyte
  AST_RAM_REGION: assert property (@(posedge clk_sys) disable iff (!resetn)
    rf_in_ram == (rf_addr[11:10] == 2'b00))
    else $error("ram region decode wrong");

  // ram accesses stay off the control section
  AST_RAM_CTLQUIET: assert property (@(posedge clk_sys) disable iff (!resetn)
    (rf_rd || rf_wr) && rf_addr <= mmd_pkg::RF_RAM_LAST |=> !rf_ctl_rd && !rf_ctl_wr)
    else $error("ram access leaked to control");

  // a ram write only when the core writes
  AST_RAM_WE: assert property (@(posedge clk_sys) disable iff (!resetn)
    ram_we |-> rf_wr)
    else $error("ram written without a write");

  // written byte reads back on the next access
  AST_RAM_READBACK: assert property (@(posedge clk_sys) disable iff (!resetn)
    rf_wr && rf_addr <= mmd_pkg::RF_RAM_LAST ##1 rf_rd && rf_addr == $past(rf_addr) && !rf_wr
      |=> rf_rdata == $past(rf_wdata, 2))
    else $error("ram readback mismatch");

  // no request, no control strobe
  AST_RF_IDLE: assert property (@(posedge clk_sys) disable iff (!resetn)
    !rf_rd && !rf_wr |=> !rf_ctl_rd && !rf_ctl_wr)
    else $error("control strobe without request");

  // ==========================================================
  // checks on the program memory side

  // flash reads leave with the low address bits
  AST_FL_RSTROBE: assert property (@(posedge clk_sys) disable iff (!resetn)
    pm_rd && pm_addr <= flash_last && !pm_in_info |=> fl_rd &&
      fl_addr == $past(pm_addr[12:0]))
    else $error("flash read not forwarded");

  // flash data is passed through unchanged
  AST_FL_RDATA: assert property (@(posedge clk_sys) disable iff (!resetn)
    pm_rd && pm_addr <= flash_last && !pm_in_info |=> pm_rdata == fl_rdata)
    else $error("flash read data not passed");

  // flash writes carry their data
  AST_FL_WSTROBE: assert property (@(posedge clk_sys) disable iff (!resetn)
    pm_wr && pm_addr <= flash_last && !pm_in_info |=> fl_wr &&
      fl_wdata == $past(pm_wdata))
    else $error("flash write not forwarded");

  // beyond flash: erased pattern
  AST_PM_BLANK: assert property (@(posedge clk_sys) disable iff (!resetn)
    pm_rd && pm_addr > flash_last && !pm_in_info |=> pm_rdata == mmd_pkg::PM_BLANK)
    else $error("unimplemented program read not ff");

  // beyond flash: no flash read either
  AST_BLANK_NORD: assert property (@(posedge clk_sys) disable iff (!resetn)
    pm_rd && pm_addr > flash_last |=> !fl_rd)
    else $error("read beyond flash reached flash");

  // beyond flash: writes dropped
  AST_PM_NOWRITE: assert property (@(posedge clk_sys) disable iff (!resetn)
    pm_wr && pm_addr > flash_last |=> !fl_wr)
    else $error("write beyond flash reached flash");

  // no request, no flash strobe
  AST_PM_IDLE: assert property (@(posedge clk_sys) disable iff (!resetn)
    !pm_rd && !pm_wr |=> !fl_rd && !fl_wr)
    else $error("flash strobe without request");

  // reset vector lives in flash at its fixed offset
  AST_RST_VEC: assert property (@(posedge clk_sys) disable iff (!resetn)
    pm_rd && pm_addr == mmd_pkg::PM_RST_VEC |=> fl_rd &&
      fl_addr == 13'(mmd_pkg::PM_RST_VEC))
    else $error("reset vector not in flash");

  // trap vector lives in flash at its fixed offset
  AST_TRAP_VEC: assert property (@(posedge clk_sys) disable iff (!resetn)
    pm_rd && pm_addr == mmd_pkg::PM_TRAP_VEC |=> fl_rd &&
      fl_addr == 13'(mmd_pkg::PM_TRAP_VEC))
    else $error("trap vector not in flash");

  // code area starts in flash
  AST_CODE_START: assert property (@(posedge clk_sys) disable iff (!resetn)
    pm_rd && pm_addr == mmd_pkg::PM_CODE_BASE |=> fl_rd)
    else $error("code start not in flash");

  // last flash byte still reads flash
  AST_FLASH_END: assert property (@(posedge clk_sys) disable iff (!resetn)
    pm_rd && pm_addr == flash_last |=> fl_rd)
    else $error("flash end not in flash");

  // first byte past the end is blank
  AST_FLASH_PAST: assert property (@(posedge clk_sys) disable iff (!resetn)
    pm_rd && pm_addr == flash_last + 16'h0001 |=> !fl_rd &&
      pm_rdata == mmd_pkg::PM_BLANK)
    else $error("flash runs past its end");

  // ==========================================================
  // checks on data memory and the information area

  // data memory never answers anything but the filler
  AST_DM_ZERO: assert property (@(posedge clk_sys) disable iff (!resetn)
    dm_rdata == mmd_pkg::DM_DATA)
    else $error("data memory answered");

  // overlay only with the page bit set
  AST_INFO_EN: assert property (@(posedge clk_sys) disable iff (!resetn)
    pm_in_info |-> page_sel[mmd_pkg::PAGE_INFO_BIT])
    else $error("overlay without page bit");

  // first part byte replaces program data
  AST_INFO_OVERLAY: assert property (@(posedge clk_sys) disable iff (!resetn)
    pm_rd && page_sel[mmd_pkg::PAGE_INFO_BIT] && pm_addr == mmd_pkg::INFO_PART_FIRST
      |=> pm_rdata == PART_ID[159:152] && !fl_rd)
    else $error("info overlay wrong");

  // any overlay byte comes from the area, never flash
  AST_INFO_DATA: assert property (@(posedge clk_sys) disable iff (!resetn)
    pm_rd && pm_in_info |=> pm_rdata == $past(info_byte) && !fl_rd)
    else $error("overlay data not from area");

  // area is read only
  AST_INFO_RO: assert property (@(posedge clk_sys) disable iff (!resetn)
    pm_wr && page_sel[mmd_pkg::PAGE_INFO_BIT] && pm_addr >= mmd_pkg::INFO_BASE |=> !fl_wr)
    else $error("info write reached flash");

  // last part byte at the top of the window
  AST_PART_LAST: assert property (@(posedge clk_sys) disable iff (!resetn)
    pm_rd && pm_in_info && pm_addr == mmd_pkg::INFO_PART_LAST |=> pm_rdata == PART_ID[7:0])
    else $error("part id last byte wrong");

  // reserved below the part id
  AST_INFO_RSVD_LO: assert property (@(posedge clk_sys) disable iff (!resetn)
    pm_rd && pm_in_info && pm_addr < mmd_pkg::INFO_PART_FIRST
      |=> pm_rdata == mmd_pkg::INFO_RSVD)
    else $error("reserved info byte below part id");

  // reserved above the part id
  AST_INFO_RSVD_HI: assert property (@(posedge clk_sys) disable iff (!resetn)
    pm_rd && pm_in_info && pm_addr > mmd_pkg::INFO_PART_LAST
      |=> pm_rdata == mmd_pkg::INFO_RSVD)
    else $error("reserved info byte above part id");

  // bit clear: top page decodes as plain program memory
  AST_INFO_OFF: assert property (@(posedge clk_sys) disable iff (!resetn)
    pm_rd && !page_sel[mmd_pkg::PAGE_INFO_BIT] && pm_addr >= mmd_pkg::INFO_BASE
      |=> pm_rdata == mmd_pkg::PM_BLANK)
    else $error("overlay active with bit clear");

  // bit clear: no overlay decode at all
  AST_INFO_OFF_DEC: assert property (@(posedge clk_sys) disable iff (!resetn)
    !page_sel[mmd_pkg::PAGE_INFO_BIT] |-> !pm_in_info)
    else $error("overlay decoded with bit clear");

  // overlay reads never touch flash
  AST_INFO_NOFL: assert property (@(posedge clk_sys) disable iff (!resetn)
    pm_rd && pm_in_info |=> !fl_rd)
    else $error("overlay read reached flash");
endmodule : mmd_decoder

// [hdl/mmd_pkg.sv]
package mmd_pkg;
  // ==========================================================
  // register file map
  localparam int unsigned RF_AW = 12;
  localparam logic [11:0] RF_RAM_BASE = 12'h000;
  localparam int unsigned RF_RAM_BYTES = 1024;
  localparam logic [11:0] RF_RAM_LAST = 12'h3ff;
  localparam logic [11:0] RF_CTL_BASE = 12'hf00;
  localparam logic [7:0] RF_GAP_DATA = 8'h00;
  // ==========================================================
  // program memory map
  localparam int unsigned PM_AW = 16;
  localparam logic [15:0] PM_FLASH_LAST_8K = 16'h1fff;
  localparam logic [15:0] PM_FLASH_LAST_4K = 16'h0fff;
  localparam logic [15:0] PM_OPT_BASE = 16'h0000;
  localparam logic [15:0] PM_RST_VEC = 16'h0002;
  localparam logic [15:0] PM_WDT_VEC = 16'h0004;
  localparam logic [15:0] PM_TRAP_VEC = 16'h0006;
  localparam logic [15:0] PM_IRQ_VEC_BASE = 16'h0008;
  localparam logic [15:0] PM_CODE_BASE = 16'h0038;
  localparam logic [7:0] PM_BLANK = 8'hff;
  // ==========================================================
  // information area and data memory filler
  localparam logic [15:0] INFO_BASE = 16'hfe00;
  localparam logic [15:0] INFO_PART_FIRST = 16'hfe40;
  localparam logic [15:0] INFO_PART_LAST = 16'hfe53;
  localparam int unsigned INFO_PART_LEN = 20;
  localparam int unsigned PAGE_INFO_BIT = 7;
  localparam logic [7:0] INFO_RSVD = 8'h00;
  localparam logic [7:0] DM_DATA = 8'h00;
  // ==========================================================
  // region selector
  typedef enum logic [1:0] {
    MMD_REG_RAM = 2'b00,
    MMD_REG_CTL = 2'b01,
    MMD_REG_GAP = 2'b11
  } mmd_rf_region_t;
endpackage : mmd_pkg

// [hdl/mmd_info_rom.sv]
`timescale 1ns/1ps
// ==========================================================
// read-only information area, fixed contents
module mmd_info_rom (
  input wire logic [8:0] addr, // offset within the area
  input wire logic [159:0] part_id, // 20 ascii chars, first char in top byte
  output logic [7:0] data // area byte
);
  logic [15:0] full_addr;
  logic in_part;
  logic [4:0] idx;
  assign full_addr = mmd_pkg::INFO_BASE | {7'h00, addr};
  // part identifier window, other locations reserved read as zero
  assign in_part = (full_addr >= mmd_pkg::INFO_PART_FIRST) &&
                   (full_addr <= mmd_pkg::INFO_PART_LAST);
  assign idx = 5'(full_addr - mmd_pkg::INFO_PART_FIRST);
  assign data = in_part ? part_id[8'(159 - 8 * idx) -: 8] : mmd_pkg::INFO_RSVD;
endmodule : mmd_info_rom

// [tb/mmd_far_model.sv]
`timescale 1ns/1ps
// ==========================================================
// flash array and control registers beyond the decoder
module mmd_far_model (
  input wire logic clk_sys, // system clock
  input wire logic fl_rd, // flash read strobe
  input wire logic fl_wr, // flash write strobe
  input wire logic [12:0] fl_addr, // flash address
  input wire logic [7:0] fl_wdata, // flash write data
  output logic [7:0] fl_rdata, // flash data
  input wire logic rf_ctl_rd, // control read strobe
  input wire logic rf_ctl_wr, // control write strobe
  input wire logic [7:0] rf_ctl_addr, // control offset
  input wire logic [7:0] rf_ctl_wdata, // control write data
  output logic [7:0] ctl_rdata // control data
);
  logic [7:0] fl_mem [0:8191];
  logic [7:0] ctl_mem [0:255];
  logic [7:0] fl_last_q = 8'h00;
  logic [7:0] ctl_last_q = 8'h00;
  logic ctl_rd_q = 1'b0;
  // preload with address patterns the bench can predict
  initial begin
    for (int i = 0; i < 8192; i++) fl_mem[i] = 8'(i) ^ 8'h3c;
    for (int i = 0; i < 256; i++) ctl_mem[i] = 8'(i) ^ 8'ha5;
  end
  // data while strobed (control data also the cycle after), else a flipping value so stale data never matches
  assign fl_rdata = fl_rd ? fl_mem[fl_addr] : ~fl_last_q;
  assign ctl_rdata = (rf_ctl_rd | ctl_rd_q) ? ctl_mem[rf_ctl_addr] : ~ctl_last_q;
  // storage updates and idle pattern history
  always @(posedge clk_sys) begin
    fl_last_q <= fl_rdata;
    ctl_last_q <= ctl_rdata;
    ctl_rd_q <= rf_ctl_rd;
    if (fl_wr) fl_mem[fl_addr] <= fl_wdata;
    if (rf_ctl_wr) ctl_mem[rf_ctl_addr] <= rf_ctl_wdata;
  end
endmodule : mmd_far_model

// [tb/testbench.sv]
`timescale 1ns/1ps
// ==========================================================
// bench for the address decoder
module testbench;
  localparam logic [159:0] PID = {8'h41, 8'h42, {18{8'h00}}}; // arbitrary value
  logic clk_sys = 1'b0, resetn = 1'b0, rf_rd = 1'b0, rf_wr = 1'b0, pm_rd = 1'b0;
  logic pm_wr = 1'b0, dm_rd = 1'b0, rf_ctl_rd, rf_ctl_wr, fl_rd, fl_wr;
  logic [11:0] rf_addr = 12'h000;
  logic [15:0] pm_addr = 16'h0000;
  logic [7:0] rf_wdata = 8'h00, pm_wdata = 8'h00, page_sel = 8'h00;
  logic [7:0] rf_rdata, rf_ctl_addr, rf_ctl_wdata, ctl_rdata, pm_rdata, fl_wdata;
  logic [7:0] fl_rdata, dm_rdata;
  logic [12:0] fl_addr;
  int n_errors = 0, n_tests = 0;
  always #2 clk_sys = ~clk_sys;
  mmd_decoder #(.FLASH_8K(1'b1), .PART_ID(PID)) uut (.clk_sys(clk_sys), .resetn(resetn),
    .rf_rd(rf_rd), .rf_wr(rf_wr), .rf_addr(rf_addr), .rf_wdata(rf_wdata), .rf_rdata(rf_rdata),
    .rf_ctl_rd(rf_ctl_rd), .rf_ctl_wr(rf_ctl_wr), .rf_ctl_addr(rf_ctl_addr),
    .rf_ctl_wdata(rf_ctl_wdata), .ctl_rdata(ctl_rdata), .pm_rd(pm_rd), .pm_wr(pm_wr),
    .pm_addr(pm_addr), .pm_wdata(pm_wdata), .page_sel(page_sel), .pm_rdata(pm_rdata),
    .fl_rd(fl_rd), .fl_wr(fl_wr), .fl_addr(fl_addr), .fl_wdata(fl_wdata),
    .fl_rdata(fl_rdata), .dm_rd(dm_rd), .dm_rdata(dm_rdata));
  mmd_far_model far (.clk_sys(clk_sys), .fl_rd(fl_rd), .fl_wr(fl_wr), .fl_addr(fl_addr),
    .fl_wdata(fl_wdata), .fl_rdata(fl_rdata), .rf_ctl_rd(rf_ctl_rd), .rf_ctl_wr(rf_ctl_wr),
    .rf_ctl_addr(rf_ctl_addr), .rf_ctl_wdata(rf_ctl_wdata), .ctl_rdata(ctl_rdata));
  // one comparison, reported at once on mismatch
  task automatic chk(input logic ok, input string msg);
    n_tests++;
    if (ok !== 1'b1) begin
      n_errors++;
      $display("[FAIL] %0t %s", $time, msg);
    end
  endtask : chk
  // one register cycle; answer sampled just after the taking edge
  task automatic rf_acc(input logic wr, input logic [11:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    rf_wr <= wr;
    rf_rd <= ~wr;
    rf_addr <= a;
    rf_wdata <= d;
    @(posedge clk_sys);
    rf_wr <= 1'b0;
    rf_rd <= 1'b0;
    #1;
  endtask : rf_acc
  // one program memory cycle, same timing
  task automatic pm_acc(input logic wr, input logic [15:0] a, input logic [7:0] d,
                        input logic [7:0] ps);
    @(posedge clk_sys);
    pm_wr <= wr;
    pm_rd <= ~wr;
    pm_addr <= a;
    pm_wdata <= d;
    page_sel <= ps;
    @(posedge clk_sys);
    pm_wr <= 1'b0;
    pm_rd <= 1'b0;
    #1;
  endtask : pm_acc
  // ram ends, gap write must not alias into ram
  task automatic t_ram;
    rf_acc(1'b1, 12'h000, 8'h5a);
    rf_acc(1'b1, 12'h3ff, 8'ha5);
    rf_acc(1'b1, 12'h400, 8'h77);
    rf_acc(1'b0, 12'h000, 8'h00);
    chk(rf_rdata === 8'h5a, "ram 000");
    rf_acc(1'b0, 12'h3ff, 8'h00);
    chk(rf_rdata === 8'ha5, "ram 3ff");
    rf_acc(1'b0, 12'h400, 8'h00);
    chk(rf_rdata === 8'h00 && rf_ctl_rd === 1'b0, "gap read");
  endtask : t_ram
  // control section forwarding; only implemented offsets are written
  task automatic t_ctl;
    rf_acc(1'b1, 12'hf00, 8'hc3);
    chk(rf_ctl_wr === 1'b1 && rf_ctl_addr === 8'h00 && rf_ctl_wdata === 8'hc3, "ctl wr");
    rf_acc(1'b0, 12'hf00, 8'h00);
    chk(rf_rdata === 8'hc3, "ctl f00");
    rf_acc(1'b0, 12'hfff, 8'h00);
    chk(rf_rdata === 8'h5a && rf_ctl_addr === 8'hff, "ctl fff");
  endtask : t_ctl
  // reset vector, flash end, blank space, ignored writes
  task automatic t_pm;
    pm_acc(1'b0, 16'h0002, 8'h00, 8'h00);
    chk(pm_rdata === 8'h3e, "reset vector");
    pm_acc(1'b0, 16'h1fff, 8'h00, 8'h00);
    chk(pm_rdata === 8'hc3, "flash end");
    pm_acc(1'b0, 16'h2000, 8'h00, 8'h00);
    chk(pm_rdata === 8'hff && fl_rd === 1'b0, "blank read");
    pm_acc(1'b1, 16'h2000, 8'h11, 8'h00);
    chk(fl_wr === 1'b0, "blank write");
    pm_acc(1'b1, 16'h0040, 8'h11, 8'h00);
    chk(fl_wr === 1'b1 && fl_addr === 13'h0040, "flash write");
    pm_acc(1'b0, 16'hfe40, 8'h00, 8'h00);
    chk(pm_rdata === 8'hff, "overlay off");
  endtask : t_pm
  // overlay contents and read-only protection
  task automatic t_info;
    pm_acc(1'b0, 16'hfe40, 8'h00, 8'h80);
    chk(pm_rdata === PID[159:152] && fl_rd === 1'b0, "part first");
    pm_acc(1'b0, 16'hfe53, 8'h00, 8'h80);
    chk(pm_rdata === PID[7:0], "part last");
    pm_acc(1'b0, 16'hfe00, 8'h00, 8'h80);
    chk(pm_rdata === 8'h00, "info reserved");
    pm_acc(1'b1, 16'hfe40, 8'h99, 8'h80);
    chk(fl_wr === 1'b0, "info write");
    pm_acc(1'b0, 16'hfe41, 8'h00, 8'h80);
    chk(pm_rdata === PID[151:144], "part second");
  endtask : t_info
  // data memory space answers nothing
  task automatic t_dm;
    @(posedge clk_sys);
    dm_rd <= 1'b1;
    @(posedge clk_sys);
    dm_rd <= 1'b0;
    #1;
    chk(dm_rdata === 8'h00, "data memory");
  endtask : t_dm
  // verdict and end of run
  task automatic end_sim;
    $display("errors %0d comparisons %0d", n_errors, n_tests);
    if (n_errors == 0 && n_tests > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : end_sim
  // hang guard
  initial begin
    #100000;
    n_errors++;
    end_sim();
  end
  // main sequence
  initial begin
    repeat (10) @(posedge clk_sys);
    resetn <= 1'b1;
    t_ram();
    t_ctl();
    t_pm();
    t_info();
    t_dm();
    end_sim();
  end
endmodule : testbench
